// ### design/mdld_pkg.sv
// Package for the multiply/divide/logic opcode decoder.
// Assumes a byte-wide opcode stream from the fetch stage on one clock.
package mdld_pkg;

    // Opcode patterns (w/d/s bits masked out where they vary)
    localparam logic [7:0] OPC_GRP3 = 8'hF6;      // 1111011w
    localparam logic [7:0] OPC_SMUL_IMM = 8'h69;  // 011010s1
    localparam logic [7:0] OPC_AM = 8'hD4;
    localparam logic [7:0] OPC_AD = 8'hD5;
    localparam logic [7:0] OPC_ADJ_BASE = 8'h0A;
    localparam logic [7:0] OPC_SXB = 8'h98;
    localparam logic [7:0] OPC_SXW = 8'h99;
    localparam logic [7:0] OPC_AND = 8'h20;       // 001000dw
    localparam logic [7:0] OPC_OR = 8'h08;        // 000010dw
    localparam logic [7:0] OPC_TST = 8'h84;       // 1000010w
    localparam logic [7:0] OPC_TSTA = 8'hA8;      // 1010100w
    localparam logic [7:0] OPC_SH1 = 8'hD0;       // 1101000w
    localparam logic [7:0] OPC_SHCL = 8'hD2;      // 1101001w
    localparam logic [7:0] OPC_SHN = 8'hC0;       // 1100000w

    // Group reg-field codes
    localparam logic [2:0] REG_TEST = 3'h0;
    localparam logic [2:0] REG_SMUL = 3'h5;
    localparam logic [2:0] REG_DIV = 3'h6;
    localparam logic [2:0] REG_SDIV = 3'h7;

    // Clock counts: min and max, or a single fixed count
    localparam logic [6:0] CYC_SMUL_RB_MIN = 7'h19; // 25
    localparam logic [6:0] CYC_SMUL_RB_MAX = 7'h1C; // 28
    localparam logic [6:0] CYC_SMUL_RW_MIN = 7'h22; // 34
    localparam logic [6:0] CYC_SMUL_RW_MAX = 7'h25; // 37
    localparam logic [6:0] CYC_SMUL_MB_MIN = 7'h1F; // 31
    localparam logic [6:0] CYC_SMUL_MB_MAX = 7'h22; // 34
    localparam logic [6:0] CYC_SMUL_MW_MIN = 7'h28; // 40
    localparam logic [6:0] CYC_SMUL_MW_MAX = 7'h2B; // 43
    localparam logic [6:0] CYC_IMMI_R_MIN = 7'h16;  // 22
    localparam logic [6:0] CYC_IMMI_R_MAX = 7'h19;  // 25
    localparam logic [6:0] CYC_IMMI_M_MIN = 7'h1D;  // 29
    localparam logic [6:0] CYC_IMMI_M_MAX = 7'h20;  // 32
    localparam logic [6:0] CYC_DIV_RB = 7'h1D;      // 29
    localparam logic [6:0] CYC_DIV_RW = 7'h26;      // 38
    localparam logic [6:0] CYC_DIV_MB = 7'h23;      // 35
    localparam logic [6:0] CYC_DIV_MW = 7'h2C;      // 44
    localparam logic [6:0] CYC_SDIV_RB_MIN = 7'h2C; // 44
    localparam logic [6:0] CYC_SDIV_RB_MAX = 7'h34; // 52
    localparam logic [6:0] CYC_SDIV_RW_MIN = 7'h35; // 53
    localparam logic [6:0] CYC_SDIV_RW_MAX = 7'h3D; // 61
    localparam logic [6:0] CYC_SDIV_MB_MIN = 7'h32; // 50
    localparam logic [6:0] CYC_SDIV_MB_MAX = 7'h3A; // 58
    localparam logic [6:0] CYC_SDIV_MW_MIN = 7'h3B; // 59
    localparam logic [6:0] CYC_SDIV_MW_MAX = 7'h43; // 67
    localparam logic [6:0] CYC_ADJ_MUL = 7'h13;     // 19
    localparam logic [6:0] CYC_ADJ_DIV = 7'h0F;     // 15
    localparam logic [6:0] CYC_SXB = 7'h02;
    localparam logic [6:0] CYC_SXW = 7'h04;
    localparam logic [6:0] CYC_LOG_R = 7'h03;
    localparam logic [6:0] CYC_LOG_M = 7'h0A;       // 10
    localparam logic [6:0] CYC_TSTI_R = 7'h04;
    localparam logic [6:0] CYC_TSTI_M = 7'h0A;
    localparam logic [6:0] CYC_TSTA_MIN = 7'h03;
    localparam logic [6:0] CYC_TSTA_MAX = 7'h04;

    // Operations seen by the execution unit
    typedef enum logic [4:0] {
        MDLD_OP_NONE = 5'h00,
        MDLD_OP_SIGNED_MULTIPLY = 5'h01,
        MDLD_OP_SIGNED_MULTIPLY_IMM = 5'h02,
        MDLD_OP_UNSIGNED_DIVIDE = 5'h03,
        MDLD_OP_SIGNED_DIVIDE = 5'h04,
        MDLD_OP_DECIMAL_ADJUST_MULTIPLY = 5'h05,
        MDLD_OP_DECIMAL_ADJUST_DIVIDE = 5'h06,
        MDLD_OP_SIGN_EXTEND_BYTE = 5'h07,
        MDLD_OP_SIGN_EXTEND_WORD = 5'h08,
        MDLD_OP_AND = 5'h09,
        MDLD_OP_OR = 5'h0A,
        MDLD_OP_TEST_REG = 5'h0B,
        MDLD_OP_TEST_IMM = 5'h0C,
        MDLD_OP_TEST_ACC = 5'h0D,
        MDLD_OP_SHIFT = 5'h0E,
        MDLD_OP_ILLEGAL = 5'h1F
    } mdld_op_t;

    // Shift/rotate operation select
    typedef enum logic [2:0] {
        MDLD_SH_ROTATE_LEFT = 3'h0,
        MDLD_SH_ROTATE_RIGHT = 3'h1,
        MDLD_SH_ROTATE_LEFT_CARRY = 3'h2,
        MDLD_SH_ROTATE_RIGHT_CARRY = 3'h3,
        MDLD_SH_SHIFT_LEFT = 3'h4,
        MDLD_SH_LOGICAL_SHIFT_RIGHT = 3'h5,
        MDLD_SH_UNDEFINED = 3'h6,
        MDLD_SH_ARITH_SHIFT_RIGHT = 3'h7
    } mdld_shift_t;

    // Decoded instruction handed to execution
    typedef struct packed {
        mdld_op_t op;
        mdld_shift_t shift_op_select;
        logic wide;          // 16-bit operands
        logic mem;           // Memory operand (mod != 11)
        logic dir;           // d bit
        logic write_result;  // Clear for flags-only forms
        logic [1:0] imm_bytes;
        logic [6:0] cyc_min;
        logic [6:0] cyc_max;
    } mdld_dec_t;

endpackage : mdld_pkg

// ### design/mdld_decoder.sv
// Opcode decoder for multiply, divide, decimal adjust, sign extension,
// shift select and logic operations in register and memory forms.
// Assumes fetch presents one instruction byte per valid cycle and that
// execution drains each decoded result in the cycle it appears.
// How it works
// RL1: group opcode reg 101 is signed multiply, 25-28 byte, 34-37 word.
// RL2: 011010s1 is immediate signed multiply; second data byte only if s=0.
// RL3: group opcode reg 110 is unsigned divide, 29/38/35/44 clocks.
// RL4: group opcode reg 111 is signed divide with ranged clock counts.
// RL5: D4 then 0A is decimal adjust after multiply, 19 clocks.
// RL6: D5 then 0A is decimal adjust before divide, 15 clocks.
// RL7: 98 sign extends low accumulator byte to word in 2 clocks.
// RL8: 99 sign extends accumulator word into doubleword in 4 clocks.
// RL9: shift select 000-011 pick the four rotate operations.
// RL10: shift select 100/101/111 pick left, logical right, arith right.
// RL11: 001000dw is AND, 000010dw is OR; 3 register, 10 memory clocks.
// RL12: 1000010w is flags-only test, no result written, 3 or 10 clocks.
// RL13: group reg 000 is immediate test 4/10; 1010100w accumulator 3/4.
// RL14: w bit set means 16-bit operands, clear means 8-bit.
// RL15: shift select 110 is flagged undefined and never executed.
`timescale 1ns/1ps

module mdld_decoder (
    input wire logic sys_clk_i,         // 20 MHz core clock
    input wire logic rst_b_i,           // Async reset, active low
    input wire logic byte_valid_i,      // Fetch byte present
    input wire logic [7:0] byte_i,      // Instruction byte
    output logic byte_ready_o,          // Decoder takes the byte
    output logic dec_valid_o,           // Decoded result, one cycle
    output mdld_pkg::mdld_dec_t dec_o,  // Decoded fields
    output logic illegal_o              // Unknown or undefined form
);
    import mdld_pkg::*;

    typedef enum logic [1:0] {
        MDLD_ST_OPC = 2'h0,
        MDLD_ST_MODRM = 2'h1,
        MDLD_ST_ADJ = 2'h2
    } mdld_state_t;

    mdld_state_t state_q, state_d;
    logic [7:0] opc_q, opc_d;
    logic dec_valid_q, dec_valid_d;
    mdld_dec_t dec_q, dec_d;
    logic illegal_q, illegal_d;

    // Cycle window picked by operand width and location
    function automatic logic [13:0] pick4(input logic wide,
            input logic mem, input logic [13:0] rb, input logic [13:0] rw,
            input logic [13:0] mb, input logic [13:0] mw);
        logic [13:0] r;
        r = mem ? (wide ? mw : mb) : (wide ? rw : rb);
        return r;
    endfunction : pick4

    // Fetch is never stalled: every byte is decoded in one cycle
    assign byte_ready_o = 1'b1;

    // Next-state and decode
    always_comb begin
        logic [2:0] regf;
        logic mem;
        logic [13:0] cy;
        regf = byte_i[5:3];
        mem = (byte_i[7:6] != 2'h3);
        cy = 14'h0000;
        state_d = state_q;
        opc_d = opc_q;
        dec_valid_d = 1'b0;
        dec_d = dec_q;
        illegal_d = 1'b0;
        if (byte_valid_i) begin
            dec_d = '0;
            dec_d.write_result = 1'b1;
            case (state_q)
                MDLD_ST_OPC: begin
                    opc_d = byte_i;
                    dec_d.wide = byte_i[0];  // RL14
                    dec_d.dir = byte_i[1];
                    if ({byte_i[7:1], 1'b0} == OPC_GRP3 ||
                        {byte_i[7:2], 2'b01} == OPC_SMUL_IMM ||
                        {byte_i[7:2], 2'b00} == OPC_AND ||
                        {byte_i[7:2], 2'b00} == OPC_OR ||
                        {byte_i[7:1], 1'b0} == OPC_TST ||
                        {byte_i[7:1], 1'b0} == OPC_SH1 ||
                        {byte_i[7:1], 1'b0} == OPC_SHCL ||
                        {byte_i[7:1], 1'b0} == OPC_SHN) begin
                        state_d = MDLD_ST_MODRM;
                    end else if (byte_i == OPC_AM || byte_i == OPC_AD) begin
                        state_d = MDLD_ST_ADJ;
                    end else begin
                        dec_valid_d = 1'b1;
                        if (byte_i == OPC_SXB) begin
                            dec_d.op = MDLD_OP_SIGN_EXTEND_BYTE;  // RL7
                            dec_d.wide = 1'b1;
                            cy = {CYC_SXB, CYC_SXB};
                        end else if (byte_i == OPC_SXW) begin
                            dec_d.op = MDLD_OP_SIGN_EXTEND_WORD;  // RL8
                            dec_d.wide = 1'b1;
                            cy = {CYC_SXW, CYC_SXW};
                        end else if ({byte_i[7:1], 1'b0} == OPC_TSTA) begin
                            dec_d.op = MDLD_OP_TEST_ACC;  // RL13
                            dec_d.write_result = 1'b0;
                            dec_d.imm_bytes = byte_i[0] ? 2'h2 : 2'h1;
                            cy = {CYC_TSTA_MIN, CYC_TSTA_MAX};
                        end else begin
                            dec_d.op = MDLD_OP_ILLEGAL;
                            dec_d.write_result = 1'b0;
                            illegal_d = 1'b1;
                        end
                    end
                end
                MDLD_ST_ADJ: begin
                    state_d = MDLD_ST_OPC;
                    dec_valid_d = 1'b1;
                    dec_d.wide = 1'b0;
                    if (byte_i != OPC_ADJ_BASE) begin
                        // Only base ten is decoded; other bases are refused
                        dec_d.op = MDLD_OP_ILLEGAL;
                        dec_d.write_result = 1'b0;
                        illegal_d = 1'b1;
                    end else if (opc_q == OPC_AM) begin
                        dec_d.op = MDLD_OP_DECIMAL_ADJUST_MULTIPLY;  // RL5
                        cy = {CYC_ADJ_MUL, CYC_ADJ_MUL};
                    end else begin
                        dec_d.op = MDLD_OP_DECIMAL_ADJUST_DIVIDE;  // RL6
                        cy = {CYC_ADJ_DIV, CYC_ADJ_DIV};
                    end
                end
                MDLD_ST_MODRM: begin
                    state_d = MDLD_ST_OPC;
                    dec_valid_d = 1'b1;
                    dec_d.mem = mem;
                    dec_d.wide = opc_q[0];  // RL14
                    dec_d.dir = opc_q[1];
                    if ({opc_q[7:2], 2'b01} == OPC_SMUL_IMM) begin
                        // Operand is always a word here; s=0 adds a byte
                        dec_d.op = MDLD_OP_SIGNED_MULTIPLY_IMM;  // RL2
                        dec_d.wide = 1'b1;
                        dec_d.dir = 1'b0;
                        dec_d.imm_bytes = opc_q[1] ? 2'h1 : 2'h2;  // RL2
                        cy = mem ? {CYC_IMMI_M_MIN, CYC_IMMI_M_MAX}
                                 : {CYC_IMMI_R_MIN, CYC_IMMI_R_MAX};
                    end else if ({opc_q[7:2], 2'b00} == OPC_AND) begin
                        dec_d.op = MDLD_OP_AND;  // RL11
                        cy = mem ? {CYC_LOG_M, CYC_LOG_M}
                                 : {CYC_LOG_R, CYC_LOG_R};
                    end else if ({opc_q[7:2], 2'b00} == OPC_OR) begin
                        dec_d.op = MDLD_OP_OR;  // RL11
                        cy = mem ? {CYC_LOG_M, CYC_LOG_M}
                                 : {CYC_LOG_R, CYC_LOG_R};
                    end else if ({opc_q[7:1], 1'b0} == OPC_TST) begin
                        dec_d.op = MDLD_OP_TEST_REG;  // RL12
                        dec_d.write_result = 1'b0;  // RL12
                        cy = mem ? {CYC_LOG_M, CYC_LOG_M}
                                 : {CYC_LOG_R, CYC_LOG_R};
                    end else if ({opc_q[7:1], 1'b0} == OPC_GRP3) begin
                        dec_d.dir = 1'b0;
                        case (regf)
                            REG_TEST: begin
                                dec_d.op = MDLD_OP_TEST_IMM;  // RL13
                                dec_d.write_result = 1'b0;
                                dec_d.imm_bytes = opc_q[0] ? 2'h2 : 2'h1;
                                cy = mem ? {CYC_TSTI_M, CYC_TSTI_M}
                                         : {CYC_TSTI_R, CYC_TSTI_R};
                            end
                            REG_SMUL: begin
                                dec_d.op = MDLD_OP_SIGNED_MULTIPLY;  // RL1
                                cy = pick4(opc_q[0], mem,
                                    {CYC_SMUL_RB_MIN, CYC_SMUL_RB_MAX},
                                    {CYC_SMUL_RW_MIN, CYC_SMUL_RW_MAX},
                                    {CYC_SMUL_MB_MIN, CYC_SMUL_MB_MAX},
                                    {CYC_SMUL_MW_MIN, CYC_SMUL_MW_MAX});
                            end
                            REG_DIV: begin
                                dec_d.op = MDLD_OP_UNSIGNED_DIVIDE;  // RL3
                                cy = pick4(opc_q[0], mem,
                                    {CYC_DIV_RB, CYC_DIV_RB},
                                    {CYC_DIV_RW, CYC_DIV_RW},
                                    {CYC_DIV_MB, CYC_DIV_MB},
                                    {CYC_DIV_MW, CYC_DIV_MW});
                            end
                            REG_SDIV: begin
                                dec_d.op = MDLD_OP_SIGNED_DIVIDE;  // RL4
                                cy = pick4(opc_q[0], mem,
                                    {CYC_SDIV_RB_MIN, CYC_SDIV_RB_MAX},
                                    {CYC_SDIV_RW_MIN, CYC_SDIV_RW_MAX},
                                    {CYC_SDIV_MB_MIN, CYC_SDIV_MB_MAX},
                                    {CYC_SDIV_MW_MIN, CYC_SDIV_MW_MAX});
                            end
                            default: begin
                                // Other group members belong to another unit
                                dec_d.op = MDLD_OP_NONE;
                                dec_d.write_result = 1'b0;
                            end
                        endcase
                    end else begin
                        // Shift group: timing lives with the shifter
                        dec_d.op = MDLD_OP_SHIFT;
                        dec_d.shift_op_select = mdld_shift_t'(regf);  // RL9
                        dec_d.imm_bytes =
                            ({opc_q[7:1], 1'b0} == OPC_SHN) ? 2'h1 : 2'h0;
                        if (regf == 3'h6) begin
                            // Undefined select is refused, never executed
                            dec_d.op = MDLD_OP_ILLEGAL;  // RL15
                            dec_d.shift_op_select = MDLD_SH_UNDEFINED;
                            dec_d.write_result = 1'b0;
                            illegal_d = 1'b1;  // RL15
                        end else if (regf[2]) begin
                            dec_d.shift_op_select = mdld_shift_t'(regf);  // RL10
                        end
                    end
                end
                default: begin
                    state_d = MDLD_ST_OPC;
                end
            endcase
            dec_d.cyc_min = cy[13:7];
            dec_d.cyc_max = cy[6:0];
        end
    end

    // State registers
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= MDLD_ST_OPC;
            opc_q <= 8'h00;
            dec_valid_q <= 1'b0;
            dec_q <= '0;
            illegal_q <= 1'b0;
        end else begin
            state_q <= state_d;
            opc_q <= opc_d;
            dec_valid_q <= dec_valid_d;
            dec_q <= dec_d;
            illegal_q <= illegal_d;
        end
    end

    assign dec_valid_o = dec_valid_q;
    assign dec_o = dec_q;
    assign illegal_o = illegal_q;

endmodule : mdld_decoder

// ### testbench/mdld_decoder_sva.sv
// Checker for the multiply/divide/logic opcode decoder.
// Sees only the decoder's ports; tracks opcode/second-byte phase itself.
`timescale 1ns/1ps

module mdld_decoder_chk (
    input wire logic sys_clk_i,            // Core clock
    input wire logic rst_b_i,              // Async reset, active low
    input wire logic byte_valid_i,         // Fetch byte present
    input wire logic [7:0] byte_i,         // Instruction byte
    input wire logic byte_ready_o,         // Decoder takes the byte
    input wire logic dec_valid_o,          // Decode pulse
    input wire mdld_pkg::mdld_dec_t dec_o, // Decoded fields
    input wire logic illegal_o             // Illegal pulse
);
    import mdld_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic exp2_q;
    logic exp2_d;
    logic [7:0] op_q;
    logic [7:0] op_d;
    logic [7:0] byte_q;
    logic sec;
    logic fst;
    logic grp;
    logic mem2;

    // Forms that expect a second byte (ModRM or adjust base)
    function automatic logic two_byte(input logic [7:0] b);
        casez (b)
            8'b1111011?, 8'b011010?1, 8'b1101010?, 8'b001000??,
            8'b000010??, 8'b1000010?, 8'b110100??, 8'b1100000?: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : two_byte

    // Phase tracking; op_q keeps the opcode while its second byte is due
    always_comb begin
        exp2_d = exp2_q;
        op_d = op_q;
        if (byte_valid_i) begin
            exp2_d = exp2_q ? 1'b0 : two_byte(byte_i);
            op_d = exp2_q ? op_q : byte_i;
        end
    end

    // Registers, cleared with the decoder so phases stay aligned
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            exp2_q <= 1'b0;
            op_q <= 8'h00;
            byte_q <= 8'h00;
        end else begin
            exp2_q <= exp2_d;
            op_q <= op_d;
            byte_q <= byte_i;
        end
    end

    // Qualifiers; mem2 reads the second byte one cycle late
    assign sec = byte_valid_i && exp2_q;
    assign fst = byte_valid_i && !exp2_q;
    assign grp = op_q[7:1] == 7'h7B;
    assign mem2 = byte_q[7:6] != 2'h3;

    a_sxb_decode: assert property (fst && byte_i == 8'h98 |=> dec_valid_o &&
        dec_o.op == MDLD_OP_SIGN_EXTEND_BYTE && dec_o.cyc_max == 7'h02)
        else $error("byte sign extend decode wrong");
    a_sxw_decode: assert property (fst && byte_i == 8'h99 |=> dec_valid_o &&
        dec_o.op == MDLD_OP_SIGN_EXTEND_WORD && dec_o.cyc_min == 7'h04)
        else $error("word sign extend decode wrong");
    a_mul_cycles: assert property (sec && grp && byte_i == 8'hE8 |=>
        dec_o.op == MDLD_OP_SIGNED_MULTIPLY &&
        dec_o.cyc_min == (op_q[0] ? 7'h22 : 7'h19)) else $error("mul clocks");
    a_imm_mul: assert property (sec && op_q[7:2] == 6'h1A && op_q[0] |=>
        dec_o.imm_bytes == (op_q[1] ? 2'h1 : 2'h2) &&
        dec_o.cyc_min == (mem2 ? 7'h1D : 7'h16)) else $error("imm mul");
    a_div_cycles: assert property (sec && grp && byte_i[5:3] == 3'h6 |=>
        dec_o.cyc_min == dec_o.cyc_max && dec_o.cyc_min == (mem2 ?
        (op_q[0] ? 7'h2C : 7'h23) : (op_q[0] ? 7'h26 : 7'h1D)))
        else $error("divide clocks");
    a_signed_divide_span: assert property (sec && grp && byte_i[5:3] == 3'h7 |=>
        dec_o.cyc_max - dec_o.cyc_min == 7'h08 && dec_o.cyc_min == (mem2 ?
        (op_q[0] ? 7'h3B : 7'h32) : (op_q[0] ? 7'h35 : 7'h2C)))
        else $error("signed divide clocks");
    a_adjust_ops: assert property (sec && op_q[7:1] == 7'h6A &&
        byte_i == 8'h0A |=> dec_valid_o && !illegal_o &&
        dec_o.cyc_max == (op_q[0] ? 7'h0F : 7'h13)) else $error("adjust");
    a_shift_select: assert property (sec && (op_q[7:2] == 6'h34 ||
        op_q[7:1] == 7'h60) |=> dec_o.shift_op_select == byte_q[5:3] &&
        illegal_o == (byte_q[5:3] == 3'h6)) else $error("shift select");
    a_logic_cycles: assert property (sec && (op_q[7:2] == 6'h08 ||
        op_q[7:2] == 6'h02) |=> dec_o.write_result && dec_o.op ==
        (op_q[5] ? MDLD_OP_AND : MDLD_OP_OR) &&
        dec_o.cyc_min == (mem2 ? 7'h0A : 7'h03)) else $error("logic op");
    a_test_flags: assert property (sec && op_q[7:1] == 7'h42 |=>
        dec_o.op == MDLD_OP_TEST_REG && !dec_o.write_result)
        else $error("register test writes a result");
    a_test_imm: assert property (sec && grp && byte_i[5:3] == 3'h0 |=>
        dec_o.op == MDLD_OP_TEST_IMM && dec_o.cyc_min == (mem2 ? 7'h0A :
        7'h04)) else $error("immediate test");
    a_wide_bit: assert property (sec && grp |=> dec_valid_o &&
        dec_o.wide == op_q[0] && dec_o.mem == mem2) else $error("width bit");
    a_ready_high: assert property (byte_ready_o)
        else $error("decoder stalled");
endmodule : mdld_decoder_chk

bind mdld_decoder mdld_decoder_chk u_chk (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .byte_valid_i(byte_valid_i), .byte_i(byte_i),
    .byte_ready_o(byte_ready_o), .dec_valid_o(dec_valid_o), .dec_o(dec_o),
    .illegal_o(illegal_o));

// ### testbench/tb.sv
// Self-checking bench for the opcode decoder.
// Drives bytes straight into the ports; execution side is not modelled.
`timescale 1ns/1ps

module tb;
    import mdld_pkg::*;
    typedef struct {
        logic [7:0] b0;
        logic [7:0] b1;
        mdld_op_t op;
        logic [6:0] lo;
        logic [6:0] hi;
    } mdld_row_t;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic byte_valid_i = 1'b0;
    logic [7:0] byte_i = 8'h00;
    logic byte_ready_o;
    logic dec_valid_o;
    logic illegal_o;
    mdld_dec_t dec_o;
    int n_errors = 0;
    int total_checks = 0;
    // Second byte 00 marks a single-byte form
    mdld_row_t rows [21] = '{
        '{8'hF6, 8'hE8, MDLD_OP_SIGNED_MULTIPLY, 7'h19, 7'h1C},
        '{8'hF7, 8'hE8, MDLD_OP_SIGNED_MULTIPLY, 7'h22, 7'h25},
        '{8'hF7, 8'h28, MDLD_OP_SIGNED_MULTIPLY, 7'h28, 7'h2B},
        '{8'h6B, 8'hC0, MDLD_OP_SIGNED_MULTIPLY_IMM, 7'h16, 7'h19},
        '{8'h69, 8'h06, MDLD_OP_SIGNED_MULTIPLY_IMM, 7'h1D, 7'h20},
        '{8'hF6, 8'hF0, MDLD_OP_UNSIGNED_DIVIDE, 7'h1D, 7'h1D},
        '{8'hF7, 8'hF0, MDLD_OP_UNSIGNED_DIVIDE, 7'h26, 7'h26},
        '{8'hF6, 8'h30, MDLD_OP_UNSIGNED_DIVIDE, 7'h23, 7'h23},
        '{8'hF7, 8'h30, MDLD_OP_UNSIGNED_DIVIDE, 7'h2C, 7'h2C},
        '{8'hF6, 8'hF8, MDLD_OP_SIGNED_DIVIDE, 7'h2C, 7'h34},
        '{8'hF7, 8'h38, MDLD_OP_SIGNED_DIVIDE, 7'h3B, 7'h43},
        '{8'hD4, 8'h0A, MDLD_OP_DECIMAL_ADJUST_MULTIPLY, 7'h13, 7'h13},
        '{8'hD5, 8'h0A, MDLD_OP_DECIMAL_ADJUST_DIVIDE, 7'h0F, 7'h0F},
        '{8'h98, 8'h00, MDLD_OP_SIGN_EXTEND_BYTE, 7'h02, 7'h02},
        '{8'h99, 8'h00, MDLD_OP_SIGN_EXTEND_WORD, 7'h04, 7'h04},
        '{8'h22, 8'hC0, MDLD_OP_AND, 7'h03, 7'h03},
        '{8'h0B, 8'h06, MDLD_OP_OR, 7'h0A, 7'h0A},
        '{8'h84, 8'hC0, MDLD_OP_TEST_REG, 7'h03, 7'h03},
        '{8'hF6, 8'hC0, MDLD_OP_TEST_IMM, 7'h04, 7'h04},
        '{8'hF7, 8'h06, MDLD_OP_TEST_IMM, 7'h0A, 7'h0A},
        '{8'hA9, 8'h00, MDLD_OP_TEST_ACC, 7'h03, 7'h04}};
    logic [7:0] sh [8] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hC0, 8'hC1,
        8'hD1, 8'hD3};

    mdld_decoder u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .byte_valid_i(byte_valid_i), .byte_i(byte_i),
        .byte_ready_o(byte_ready_o), .dec_valid_o(dec_valid_o),
        .dec_o(dec_o), .illegal_o(illegal_o));

    // 50 ns period core clock
    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // Vector compare; one-bit flags go through it zero-extended
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp

    // Drive one byte just after a rising edge, held for that cycle
    task automatic step(input logic [7:0] b, input logic v);
        @(posedge sys_clk_i);
        byte_i <= b;
        byte_valid_i <= v;
    endtask : step

    // Whole form, then look at the settled result mid-cycle
    task automatic form(input logic [7:0] b0, input logic [7:0] b1);
        step(b0, 1'b1);
        if (b1 !== 8'h00) step(b1, 1'b1);
        step(8'h00, 1'b0);
        @(negedge sys_clk_i);
    endtask : form

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    // Run takes about 120 cycles; this limit is generous
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        n_errors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        cmp(8'(dec_valid_o), 8'h00, "valid in reset");
        cmp(8'(dec_o === '0), 8'h01, "fields in reset");
        cmp(8'(byte_ready_o), 8'h01, "ready");
        @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        foreach (rows[i]) begin
            form(rows[i].b0, rows[i].b1);
            cmp(8'(dec_valid_o), 8'h01, "valid");
            cmp(8'(illegal_o), 8'h00, "illegal");
            cmp(8'(dec_o.op), 8'(rows[i].op), "op");
            cmp(8'(dec_o.cyc_min), 8'(rows[i].lo), "min");
            cmp(8'(dec_o.cyc_max), 8'(rows[i].hi), "max");
        end
        for (int t = 0; t < 8; t++) begin
            form(sh[t], {2'b11, 3'(t), 3'b000});
            cmp(8'(dec_o.shift_op_select), 8'(t), "shift");
            cmp(8'(illegal_o), 8'(t == 6), "shift 110");
            cmp(8'(dec_o.wide), 8'(sh[t][0]), "wide");
        end
        form(8'h6B, 8'hC0);
        cmp(8'(dec_o.imm_bytes), 8'h01, "imm s=1");
        form(8'h69, 8'hC0);
        cmp(8'(dec_o.imm_bytes), 8'h02, "imm s=0");
        form(8'h85, 8'hC0);
        cmp(8'(dec_o.write_result), 8'h00, "test writes");
        form(8'h23, 8'hC0);
        cmp(8'(dec_o.write_result), 8'h01, "and writes");
        cmp(8'(dec_o.dir), 8'h01, "and direction");
        // Group members outside this block decode to no operation
        form(8'hF6, 8'hD0);
        cmp(8'(dec_o.op), 8'(MDLD_OP_NONE), "group other");
        cmp(8'(illegal_o), 8'h00, "group other legal");
        form(8'hD4, 8'h0B);
        cmp(8'(illegal_o), 8'h01, "adjust base");
        form(8'h0F, 8'h00);
        cmp(8'(illegal_o & dec_valid_o), 8'h01, "unknown opcode");
        // Opcode back to back after a single-byte form
        step(8'h98, 1'b1);
        step(8'hF7, 1'b1);
        @(negedge sys_clk_i);
        cmp(8'(dec_o.op), 8'(MDLD_OP_SIGN_EXTEND_BYTE), "b2b first");
        step(8'hE8, 1'b1);
        @(negedge sys_clk_i);
        cmp(8'(dec_valid_o), 8'h00, "mid form");
        step(8'h00, 1'b0);
        @(negedge sys_clk_i);
        cmp(8'(dec_o.op), 8'(MDLD_OP_SIGNED_MULTIPLY), "b2b second");
        // Reset in mid-form must drop the pending opcode
        step(8'hF7, 1'b1);
        step(8'h00, 1'b0);
        @(posedge sys_clk_i);
        rst_b_i <= 1'b0;
        @(negedge sys_clk_i);
        cmp(8'(dec_valid_o), 8'h00, "valid in second reset");
        @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        form(8'hE8, 8'h00);
        cmp(8'(illegal_o & dec_valid_o), 8'h01, "stale opcode");
        wrap_up();
    end
endmodule : tb
